// ### hdl/temp_i2c_pkg.sv
/*
 * Shared constants and types for the temperature sensor two-wire slave and alarm.
 * Assumes: included in compile order before the slave module; nothing imported.
 */
`default_nettype none

package temp_i2c_pkg;

	// ==========================================================
	// register pointer codes
	localparam logic [2:0] PTR_TEMP  = 3'h0;
	localparam logic [2:0] PTR_CFG   = 3'h1;
	localparam logic [2:0] PTR_HYST  = 3'h2;
	localparam logic [2:0] PTR_HIGH  = 3'h3;
	localparam logic [2:0] PTR_RESET = 3'h0;

	// ==========================================================
	// values after reset
	localparam logic [7:0]  CFG_RESET  = 8'h00;
	localparam logic [15:0] HYST_RESET = 16'h4B00;
	localparam logic [15:0] HIGH_RESET = 16'h5500;

	// ==========================================================
	// framing counts
	localparam logic [2:0] LAST_BIT       = 3'h7;
	localparam logic [1:0] MAX_READ_BYTES = 2'h3;
	localparam logic [1:0] LAST_BYTE_IDX  = 2'h3;
	localparam int         ADDR_LOW_BITS  = 3;

	// ==========================================================
	// fault queue lengths, selected by the two fault queue bits
	localparam logic [2:0] FAULTS_SEL0 = 3'h1;
	localparam logic [2:0] FAULTS_SEL1 = 3'h2;
	localparam logic [2:0] FAULTS_SEL2 = 3'h4;
	localparam logic [2:0] FAULTS_SEL3 = 3'h6;

	// ==========================================================
	// configuration byte layout, msb first
	typedef struct packed {
		logic [2:0] channel_sel;
		logic [1:0] fault_queue;
		logic       alarm_polarity_bit;
		logic       alarm_mode_bit;
		logic       shutdown_bit;
	} cfg_t;

	typedef enum logic [2:0] {
		LS_IDLE,
		LS_ADDR,
		LS_ADDR_ACK,
		LS_WR,
		LS_WR_ACK,
		LS_RD,
		LS_RD_ACK,
		LS_LOCK
	} link_state_t;

endpackage

`default_nettype wire

// ### hdl/temp_sensor_i2c_slave_alarm.sv
/*
 * Two-wire slave interface and overtemperature alarm of a temperature sensor.
 * Assumes: scl_i is the bus clock and stands still (high) between frames; the
 * converter runs on mclk_i and reports readings with a one-cycle temp_valid_i;
 * pins are resolved outside from the output enables (open drain, low only).
 */
`default_nettype none

module temp_sensor_i2c_slave_alarm #(
	parameter logic [3:0] ADDR_HIGH_NIBBLE = 4'hC, // arbitrary value
	parameter int         SINGLE_INPUT     = 0
) (
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       addr_strap_pin_2_i,
	input  wire logic       addr_strap_pin_1_i,
	input  wire logic       addr_strap_pin_0_i,
	input  wire logic [9:0] temp_value_i,
	input  wire logic       temp_valid_i,
	input  wire logic       conv_busy_i,
	output logic            conv_abort_o,
	output logic            conv_restart_o,
	output logic            shutdown_o,
	output logic            over_temp_alarm_out_o,
	output logic            over_temp_alarm_out_oe_o
);

	// ==========================================================
	// elaboration checks
	if (SINGLE_INPUT != 0 && SINGLE_INPUT != 1) begin : g_bad_variant
		$error("SINGLE_INPUT must be 0 or 1");
	end

	// ==========================================================
	// start and stop detection on sda edges
	logic start_tog;
	logic stop_tog;

	always_ff @(negedge sda_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_tog <= 1'b0;
		end else if (scl_i) begin
			start_tog <= ~start_tog;
		end
	end

	always_ff @(posedge sda_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stop_tog <= 1'b0;
		end else if (scl_i) begin
			stop_tog <= ~stop_tog;
		end
	end

	// ==========================================================
	// link domain: byte framing on scl
	// reset releases while scl stands high, so no edge races the release
	temp_i2c_pkg::link_state_t state;
	logic [2:0]  bit_cnt;
	logic [7:0]  shreg;
	logic        rw;
	logic [1:0]  byte_idx;
	logic [1:0]  rd_bytes;
	logic        start_seen;
	logic [2:0]  strap_meta;
	logic [2:0]  strap_sync;
	logic [2:0]  ptr;
	temp_i2c_pkg::cfg_t cfg;
	logic [8:0]  hyst;
	logic [8:0]  high;
	logic        wr_tog;
	logic        rd_tog;
	logic        sda_low;
	logic [7:0]  tx;
	logic [7:0]  tx_byte;
	logic [9:0]  temp_hold;

	wire logic       start_new = start_tog ^ start_seen;
	wire logic [7:0] byte_in   = {shreg[6:0], sda_i};
	wire logic [6:0] own_addr  = {ADDR_HIGH_NIBBLE,
		(SINGLE_INPUT == 1) ? 3'h0 : strap_sync};
	wire logic       wr_byte   = !start_new && state == temp_i2c_pkg::LS_WR
		&& bit_cnt == temp_i2c_pkg::LAST_BIT;

	always_ff @(posedge scl_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strap_meta <= 3'h0;
			strap_sync <= 3'h0;
		end else begin
			strap_meta <= {addr_strap_pin_2_i, addr_strap_pin_1_i, addr_strap_pin_0_i};
			strap_sync <= strap_meta;
		end
	end

	always_ff @(posedge scl_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state      <= temp_i2c_pkg::LS_IDLE;
			bit_cnt    <= 3'h0;
			shreg      <= 8'h00;
			rw         <= 1'b0;
			byte_idx   <= 2'h0;
			rd_bytes   <= 2'h0;
			start_seen <= 1'b0;
		end else begin
			start_seen <= start_tog;
			shreg      <= byte_in;
			bit_cnt    <= bit_cnt + 3'h1;
			if (state == temp_i2c_pkg::LS_LOCK) begin
				state <= temp_i2c_pkg::LS_LOCK;
			end else if (start_new) begin
				state    <= temp_i2c_pkg::LS_ADDR;
				bit_cnt  <= 3'h1;
				rd_bytes <= 2'h0;
			end else begin
				case (state)
					temp_i2c_pkg::LS_ADDR: begin
						if (bit_cnt == temp_i2c_pkg::LAST_BIT) begin
							if (shreg[6:0] == own_addr) begin
								rw    <= sda_i;
								state <= temp_i2c_pkg::LS_ADDR_ACK;
							end else begin
								state <= temp_i2c_pkg::LS_IDLE;
							end
						end
					end
					temp_i2c_pkg::LS_ADDR_ACK: begin
						bit_cnt  <= 3'h0;
						byte_idx <= 2'h0;
						state    <= rw ? temp_i2c_pkg::LS_RD : temp_i2c_pkg::LS_WR;
					end
					temp_i2c_pkg::LS_WR: begin
						if (bit_cnt == temp_i2c_pkg::LAST_BIT) begin
							state <= temp_i2c_pkg::LS_WR_ACK;
						end
					end
					temp_i2c_pkg::LS_WR_ACK: begin
						bit_cnt <= 3'h0;
						state   <= temp_i2c_pkg::LS_WR;
						if (byte_idx != temp_i2c_pkg::LAST_BYTE_IDX) begin
							byte_idx <= byte_idx + 2'h1;
						end
					end
					temp_i2c_pkg::LS_RD: begin
						if (rd_bytes == temp_i2c_pkg::MAX_READ_BYTES) begin
							state <= temp_i2c_pkg::LS_LOCK;
						end else if (bit_cnt == temp_i2c_pkg::LAST_BIT) begin
							state <= temp_i2c_pkg::LS_RD_ACK;
						end
					end
					temp_i2c_pkg::LS_RD_ACK: begin
						bit_cnt  <= 3'h0;
						rd_bytes <= rd_bytes + 2'h1;
						if (byte_idx != temp_i2c_pkg::LAST_BYTE_IDX) begin
							byte_idx <= byte_idx + 2'h1;
						end
						// a not-acknowledge ends our part of the read
						state <= sda_i ? temp_i2c_pkg::LS_IDLE : temp_i2c_pkg::LS_RD;
					end
					default: state <= temp_i2c_pkg::LS_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// link domain: pointer and register writes
	always_ff @(posedge scl_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ptr  <= temp_i2c_pkg::PTR_RESET;
			cfg  <= temp_i2c_pkg::cfg_t'(temp_i2c_pkg::CFG_RESET);
			hyst <= temp_i2c_pkg::HYST_RESET[15:7];
			high <= temp_i2c_pkg::HIGH_RESET[15:7];
		end else if (wr_byte) begin
			case (byte_idx)
				2'h0: ptr <= byte_in[2:0];
				2'h1: begin
					// upper byte alone gives an 8-bit threshold, lsb cleared
					case (ptr)
						temp_i2c_pkg::PTR_CFG:  cfg  <= temp_i2c_pkg::cfg_t'(byte_in);
						temp_i2c_pkg::PTR_HYST: hyst <= {byte_in, 1'b0};
						temp_i2c_pkg::PTR_HIGH: high <= {byte_in, 1'b0};
						default:                ptr  <= ptr;
					endcase
				end
				2'h2: begin
					case (ptr)
						temp_i2c_pkg::PTR_HYST: hyst[0] <= byte_in[7];
						temp_i2c_pkg::PTR_HIGH: high[0] <= byte_in[7];
						default:                ptr     <= ptr;
					endcase
				end
				default: ptr <= ptr;
			endcase
		end
	end

	// events for the system domain; data behind them stays put for many scl periods
	always_ff @(posedge scl_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_tog <= 1'b0;
			rd_tog <= 1'b0;
		end else if (!start_new) begin
			if (state == temp_i2c_pkg::LS_WR_ACK && byte_idx != 2'h0) begin
				wr_tog <= ~wr_tog;
			end
			if (state == temp_i2c_pkg::LS_ADDR_ACK && rw) begin
				rd_tog <= ~rd_tog;
			end
		end
	end

	// ==========================================================
	// link domain: read data select
	// temp_hold is frozen by the system domain while a frame is open
	always_comb begin
		tx_byte = 8'h00;
		case (ptr)
			temp_i2c_pkg::PTR_TEMP: tx_byte = byte_idx[0] ? {temp_hold[1:0], 6'h00}
				: temp_hold[9:2];
			temp_i2c_pkg::PTR_CFG:  tx_byte = cfg;
			temp_i2c_pkg::PTR_HYST: tx_byte = byte_idx[0] ? {hyst[0], 7'h00} : hyst[8:1];
			temp_i2c_pkg::PTR_HIGH: tx_byte = byte_idx[0] ? {high[0], 7'h00} : high[8:1];
			default:                tx_byte = 8'h00;
		endcase
	end

	// ==========================================================
	// link domain: sda drive on the falling scl edge
	always_ff @(negedge scl_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sda_low <= 1'b0;
			tx      <= 8'h00;
		end else if (state == temp_i2c_pkg::LS_LOCK) begin
			sda_low <= 1'b1;
		end else if (start_new) begin
			sda_low <= 1'b0;
		end else begin
			case (state)
				temp_i2c_pkg::LS_ADDR_ACK,
				temp_i2c_pkg::LS_WR_ACK: sda_low <= 1'b1;
				temp_i2c_pkg::LS_RD: begin
					if (bit_cnt == 3'h0) begin
						sda_low <= ~tx_byte[7];
						tx      <= {tx_byte[6:0], 1'b0};
					end else begin
						sda_low <= ~tx[7];
						tx      <= {tx[6:0], 1'b0};
					end
				end
				default: sda_low <= 1'b0;
			endcase
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_low;

	// ==========================================================
	// system domain: event crossing {read, write, stop, start}
	logic [3:0] evt_meta;
	logic [3:0] evt_sync;
	logic [3:0] evt_last;
	wire  logic [3:0] evt = evt_sync ^ evt_last;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			evt_meta <= 4'h0;
			evt_sync <= 4'h0;
			evt_last <= 4'h0;
		end else begin
			evt_meta <= {rd_tog, wr_tog, stop_tog, start_tog};
			evt_sync <= evt_meta;
			evt_last <= evt_sync;
		end
	end

	// ==========================================================
	// system domain: conversion abort and restart
	logic busy;
	logic aborted;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy           <= 1'b0;
			aborted        <= 1'b0;
			conv_abort_o   <= 1'b0;
			conv_restart_o <= 1'b0;
		end else begin
			conv_abort_o   <= evt[0] && conv_busy_i;
			conv_restart_o <= evt[1] && (aborted || (evt[0] && conv_busy_i));
			if (evt[1]) begin
				busy    <= 1'b0;
				aborted <= 1'b0;
			end else if (evt[0]) begin
				busy    <= 1'b1;
				aborted <= aborted || conv_busy_i;
			end
		end
	end

	// ==========================================================
	// system domain: settings copy and temperature hold
	temp_i2c_pkg::cfg_t cfg_m;
	logic [8:0] hyst_m;
	logic [8:0] high_m;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_m  <= temp_i2c_pkg::cfg_t'(temp_i2c_pkg::CFG_RESET);
			hyst_m <= temp_i2c_pkg::HYST_RESET[15:7];
			high_m <= temp_i2c_pkg::HIGH_RESET[15:7];
		end else if (evt[2]) begin
			cfg_m  <= cfg;
			hyst_m <= hyst;
			high_m <= high;
		end
	end

	wire logic new_reading = temp_valid_i && !busy && !cfg_m.shutdown_bit;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			temp_hold <= 10'h000;
		end else if (new_reading) begin
			temp_hold <= temp_value_i;
		end
	end

	// ==========================================================
	// system domain: fault queue and alarm
	logic       alarm;
	logic       wait_high;
	logic [2:0] fault_cnt;
	logic [2:0] fault_limit;
	logic       line_low;

	wire logic over  = $signed(temp_value_i[9:1]) > $signed(high_m);
	wire logic under = $signed(temp_value_i[9:1]) < $signed(hyst_m);
	wire logic look_high = cfg_m.alarm_mode_bit ? wait_high : ~alarm;
	wire logic fault = look_high ? over : under;
	wire logic hit   = new_reading && fault && (fault_cnt == fault_limit - 3'h1);

	always_comb begin
		case (cfg_m.fault_queue)
			2'h0:    fault_limit = temp_i2c_pkg::FAULTS_SEL0;
			2'h1:    fault_limit = temp_i2c_pkg::FAULTS_SEL1;
			2'h2:    fault_limit = temp_i2c_pkg::FAULTS_SEL2;
			default: fault_limit = temp_i2c_pkg::FAULTS_SEL3;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fault_cnt <= 3'h0;
		end else if (cfg_m.shutdown_bit) begin
			fault_cnt <= 3'h0;
		end else if (new_reading) begin
			// any reading that breaks the run starts the count again
			fault_cnt <= (!fault || hit) ? 3'h0 : fault_cnt + 3'h1;
		end
	end

	// a trigger in the same cycle as a read clear wins, so no event is lost
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm <= 1'b0;
		end else if (cfg_m.shutdown_bit) begin
			alarm <= 1'b0;
		end else if (hit) begin
			alarm <= cfg_m.alarm_mode_bit ? 1'b1 : ~alarm;
		end else if (evt[3] && cfg_m.alarm_mode_bit) begin
			alarm <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_high <= 1'b1;
		end else if (hit && cfg_m.alarm_mode_bit) begin
			wait_high <= ~wait_high;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			line_low <= 1'b0;
		end else begin
			line_low <= cfg_m.alarm_polarity_bit
				? ~(alarm && !cfg_m.shutdown_bit)
				: (alarm && !cfg_m.shutdown_bit);
		end
	end

	// open drain: never drive high, only sink
	assign over_temp_alarm_out_o    = 1'b0;
	assign over_temp_alarm_out_oe_o = line_low;
	assign shutdown_o               = cfg_m.shutdown_bit;

endmodule

`default_nettype wire

// ### verif/temp_sensor_i2c_slave_alarm_props.sv
/*
 * Concurrent checks on the ports of the two-wire slave and alarm block.
 * Assumes: bound to the top module; mclk_i domain, resetn_i active low.
 */
`default_nettype none
module temp_sensor_i2c_slave_alarm_props (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic conv_busy_i,
	input wire logic conv_abort_o,
	input wire logic conv_restart_o,
	input wire logic shutdown_o,
	input wire logic over_temp_alarm_out_o,
	input wire logic over_temp_alarm_out_oe_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// ==========================================================
	// helper: an abort waits for its restart
	logic pend;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			pend <= 1'b0;
		else if (conv_abort_o)
			pend <= 1'b1;
		else if (conv_restart_o)
			pend <= 1'b0;
	end
	// ==========================================================
	// assertions
	sda_open_drain_a: assert property (sda_o == 1'b0)
		else $error("sda data driven high");
	alarm_open_drain_a: assert property (over_temp_alarm_out_o == 1'b0)
		else $error("alarm data driven high");
	sda_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("sda moved while scl high");
	abort_pulse_a: assert property (conv_abort_o |=> !conv_abort_o)
		else $error("abort longer than one cycle");
	restart_pulse_a: assert property (conv_restart_o |=> !conv_restart_o)
		else $error("restart longer than one cycle");
	abort_busy_a: assert property (conv_abort_o |-> $past(conv_busy_i))
		else $error("abort without conversion");
	restart_cause_a: assert property (conv_restart_o |-> pend && !conv_abort_o)
		else $error("restart without abort");
	shut_quiet_a: assert property (shutdown_o && $past(shutdown_o, 2)
		|-> $stable(over_temp_alarm_out_oe_o))
		else $error("alarm moved in shutdown");
	cover property ($rose(conv_abort_o));
	cover property ($rose(over_temp_alarm_out_oe_o));
	cover property ($rose(shutdown_o));
endmodule
`default_nettype wire

// ### verif/i2c_master_model.sv
/*
 * Two-wire bus master model driving scl and pulling sda low.
 * Assumes: sda_i is the resolved line with a pull-up; no clock stretching.
 */
`default_nettype none
module i2c_master_model (
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// bus clock stands high between frames, 160 ns period inside
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic start();
		#83 sda_low_o = 1'b1;
		#80 scl_o = 1'b0;
	endtask
	// data moves only in the low half so no false stop is seen
	task automatic bitx(input logic b, output logic r);
		#40 sda_low_o = !b;
		#40 scl_o = 1'b1;
		#40 r = sda_i;
		#40 scl_o = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(!ack, r);
	endtask
	task automatic stop();
		#40 sda_low_o = 1'b1;
		#40 scl_o = 1'b1;
		#80 sda_low_o = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

// ### verif/temp_sensor_i2c_slave_alarm_tb_top.sv
/*
 * Self-checking bench for the two-wire slave and alarm block.
 * Assumes: the master model drives the bus; converter readings come from here.
 */
`default_nettype none
`define CHK(x, y) begin checked++; if ((x) !== (y)) begin fail_count++; \
	$display("[ERR] %0t got %0h exp %0h", $time, x, y); end end
module temp_sensor_i2c_slave_alarm_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] NIB   = 4'h9; // arbitrary value
	localparam logic [9:0] OVER  = 10'h160;
	localparam logic [9:0] INL   = 10'h140;
	localparam logic [9:0] UNDER = 10'h100;
	logic       mclk_i   = 1'b0;
	logic       resetn_i = 1'b0;
	logic       valid    = 1'b0;
	logic       busy     = 1'b0;
	logic [2:0] strap    = 3'h0;
	logic [9:0] tval     = 10'h000;
	wire logic  scl;
	wire logic  sda_low;
	wire logic  sda;
	logic       oe;
	logic       aoe;
	logic       ab;
	logic       rs;
	logic       shut;
	logic       a;
	logic [6:0] addr;
	logic [7:0] cfg  = 8'h00;
	logic [8:0] hyst = 9'h096;
	logic [8:0] high = 9'h0AA;
	logic [9:0] temp = 10'h000;
	int fail_count = 0;
	int checked    = 0;
	int n_ab       = 0;
	int n_rs       = 0;
	int nq[4]      = '{1, 2, 4, 6};
	assign sda = !(sda_low | oe);
	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (ab) n_ab++;
		if (rs) n_rs++;
	end
	i2c_master_model i_mst (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
	temp_sensor_i2c_slave_alarm #(.ADDR_HIGH_NIBBLE(NIB), .SINGLE_INPUT(0)) i_dut (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe_o(oe), .addr_strap_pin_2_i(strap[2]),
		.addr_strap_pin_1_i(strap[1]), .addr_strap_pin_0_i(strap[0]),
		.temp_value_i(tval), .temp_valid_i(valid), .conv_busy_i(busy),
		.conv_abort_o(ab), .conv_restart_o(rs), .shutdown_o(shut),
		.over_temp_alarm_out_o(), .over_temp_alarm_out_oe_o(aoe));
	// ==========================================================
	// expectations and bus tasks
	function automatic logic [15:0] exp_of(input logic [2:0] p);
		case (p)
			3'h0: return {temp, 6'h00};
			3'h1: return {cfg, cfg};
			3'h2: return {hyst, 7'h00};
			3'h3: return {high, 7'h00};
			default: return 16'h0000;
		endcase
	endfunction
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
		logic k;
		i_mst.start();
		i_mst.wbyte({addr, 1'b0}, k);
		`CHK(k, 1'b1)
		i_mst.wbyte(p, k);
		for (int i = 0; i < n; i++) i_mst.wbyte(i ? d[7:0] : d[15:8], k);
		i_mst.stop();
		repeat (10) @(posedge mclk_i);
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		logic       k;
		logic [7:0] d;
		logic [15:0] e;
		e = exp_of(p[2:0]);
		wr(p, 16'h0000, 0);
		i_mst.start();
		i_mst.wbyte({addr, 1'b1}, k);
		`CHK(k, 1'b1)
		for (int i = 0; i < n; i++) begin
			i_mst.rbyte(d, i < n - 1);
			`CHK(d, i ? e[7:0] : e[15:8])
		end
		i_mst.stop();
		repeat (10) @(posedge mclk_i);
	endtask
	task automatic wcfg(input logic [7:0] v);
		cfg = v;
		wr(8'h01, {v, 8'h00}, 1);
	endtask
	task automatic rdg(input logic [9:0] t);
		@(posedge mclk_i) begin
			tval <= t;
			valid <= 1'b1;
		end
		@(posedge mclk_i) valid <= 1'b0;
		temp = t;
		repeat (4) @(posedge mclk_i);
	endtask
	task automatic tdone(input string s);
		$display("test %0s done", s);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#3ms;
		fail_count++;
		end_sim();
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32127));
		@(posedge mclk_i) strap <= 3'($urandom);
		repeat (6) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		addr = {NIB, strap};
		`CHK(aoe, 1'b0)
		for (int i = 0; i < 7; i++) begin
			i_mst.start();
			i_mst.wbyte({addr ^ (7'h01 << i), 1'b0}, a);
			`CHK(a, 1'b0)
			i_mst.stop();
		end
		tdone("address");
		for (int q = 0; q < 4; q++) begin
			wcfg({3'h0, 2'(q), 3'h0});
			repeat (nq[q] - 1) rdg(OVER);
			rdg(INL);
			repeat (nq[q] - 1) rdg(OVER);
			`CHK(aoe, 1'b0)
			rdg(OVER);
			`CHK(aoe, 1'b1)
			repeat (nq[q]) rdg(UNDER);
			`CHK(aoe, 1'b0)
		end
		wcfg(8'h04);
		`CHK(aoe, 1'b1)
		rdg(OVER);
		`CHK(aoe, 1'b0)
		rdg(UNDER);
		wcfg(8'h02);
		rdg(OVER);
		rdg(INL);
		`CHK(aoe, 1'b1)
		rd(8'h00, 2);
		`CHK(aoe, 1'b0)
		rdg(OVER);
		`CHK(aoe, 1'b0)
		rdg(UNDER);
		`CHK(aoe, 1'b1)
		wcfg(8'h03);
		`CHK(aoe, 1'b0)
		`CHK(shut, 1'b1)
		wcfg(8'h00);
		tdone("alarm");
		@(posedge mclk_i) busy <= 1'b1;
		wr(8'h00, 16'h0000, 0);
		@(posedge mclk_i) busy <= 1'b0;
		`CHK(n_ab, 1)
		`CHK(n_rs, 1)
		tdone("abort");
		for (int k = 0; k < 4; k++) begin
			hyst = 9'($urandom);
			wr(8'h02, {hyst, 7'h00}, 2);
			high = {8'($urandom), 1'b0};
			wr(8'h03, {high[8:1], 8'h00}, 1);
			wcfg(8'($urandom) & 8'h1E);
			rdg(10'($urandom));
			rd(8'h02, 2);
			rd(8'h03, 2);
			rd(8'h01, 1);
			rd(8'h00, 2);
			rd(8'h05, 2);
		end
		wcfg(8'h00);
		tdone("registers");
		wr(8'h01, 16'h0000, 0);
		i_mst.start();
		i_mst.wbyte({addr, 1'b1}, a);
		for (int i = 0; i < 3; i++) i_mst.rbyte(cfg, 1'b1);
		i_mst.bitx(1'b1, a);
		@(posedge mclk_i);
		`CHK(oe, 1'b1)
		i_mst.stop();
		repeat (20) @(posedge mclk_i);
		`CHK(oe, 1'b1)
		@(posedge mclk_i) resetn_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		`CHK(oe, 1'b0)
		wr(8'h00, 16'h0000, 0);
		tdone("lock");
		end_sim();
	end
endmodule
bind temp_sensor_i2c_slave_alarm temp_sensor_i2c_slave_alarm_props i_props (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .conv_busy_i(conv_busy_i), .conv_abort_o(conv_abort_o),
	.conv_restart_o(conv_restart_o), .shutdown_o(shutdown_o),
	.over_temp_alarm_out_o(over_temp_alarm_out_o),
	.over_temp_alarm_out_oe_o(over_temp_alarm_out_oe_o));
`default_nettype wire
